// ### cbts_top.sv
// bit timing segments register with command access and bit sampling
`timescale 1ns/10ps
`default_nettype none
module cbts_top
    import cbts_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   cmd_valid,
    input  wire logic [7:0]             cmd_opcode,
    input  wire logic [7:0]             cmd_wdata,
    input  wire logic [CBTS_MODE_W-1:0] op_mode,
    input  wire logic                   tq_tick,
    input  wire logic                   rx_level,
    output logic                        rd_valid,
    output logic [7:0]                  rd_data,
    output logic                        wr_refused,
    output logic                        config_valid,
    output logic                        sample_strobe,
    output logic                        sampled_bit,
    output logic                        bit_end_strobe
);
    cbts_seg_if seg ();

    logic [7:0] seg_q;
    logic [7:0] seg_d;
    logic       rd_valid_q;
    logic       rd_valid_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic       wr_refused_q;
    logic       wr_refused_d;
    logic       cfg_valid_q;
    logic       cfg_valid_d;
    logic       run_q;
    logic       run_d;
    logic [1:0] hist_q;
    logic [1:0] hist_d;
    logic       sample_q;
    logic       sample_d;
    logic       bit_q;
    logic       bit_d;
    logic       bit_end_q;
    logic       bit_end_d;

    logic       is_wr;
    logic       is_rd;
    logic       in_init;
    logic       tss;
    logic       vote;

    // command decode
    assign is_wr   = cmd_valid && cmd_opcode == CBTS_OP_WRITE;
    assign is_rd   = cmd_valid && cmd_opcode == CBTS_OP_READ;
    assign in_init = op_mode[CBTS_MODE_INIT];
    assign tss     = seg_q[CBTS_TSS_BIT];
    // majority of the current level and the two previous quanta
    assign vote    = (rx_level & hist_q[0]) | (rx_level & hist_q[1])
                     | (hist_q[0] & hist_q[1]);

    // fields towards the sequencer
    assign seg.p1_code = seg_q[CBTS_P1_MSB:CBTS_P1_LSB];
    assign seg.p2_code = seg_q[CBTS_P2_MSB:CBTS_P2_LSB];
    assign seg.run     = run_q;
    assign seg.tq_tick = tq_tick;

    cbts_bit_seq u_seq (
        .clk  (clk),
        .nrst (nrst),
        .seg  (seg)
    );

    // register access next values
    always_comb begin
        seg_d        = seg_q;
        wr_refused_d = 1'b0;
        if (is_wr) begin
            if (in_init) begin
                seg_d = cmd_wdata;
            end else begin
                wr_refused_d = 1'b1;
            end
        end
        rd_valid_d = is_rd;
        rd_data_d  = is_rd ? seg_q : rd_data_q;
        cfg_valid_d = seg_q[CBTS_P1_MSB:CBTS_P1_LSB] != CBTS_P1_INVALID
                      && seg_q[CBTS_P2_MSB:CBTS_P2_LSB] != CBTS_P2_INVALID;
        // bit timing runs outside init with valid lengths only
        run_d = !in_init && cfg_valid_d;
    end

    // register access state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seg_q        <= CBTS_SEG_RESET;
            rd_valid_q   <= 1'b0;
            rd_data_q    <= CBTS_SEG_RESET;
            wr_refused_q <= 1'b0;
            cfg_valid_q  <= 1'b0;
            run_q        <= 1'b0;
        end else begin
            seg_q        <= seg_d;
            rd_valid_q   <= rd_valid_d;
            rd_data_q    <= rd_data_d;
            wr_refused_q <= wr_refused_d;
            cfg_valid_q  <= cfg_valid_d;
            run_q        <= run_d;
        end
    end

    // sampling next values
    always_comb begin
        hist_d    = seg.tq_tick ? {hist_q[0], rx_level} : hist_q;
        sample_d  = seg.sample_pt;
        bit_end_d = seg.bit_end;
        bit_d     = bit_q;
        if (seg.sample_pt) begin
            bit_d = tss ? vote : rx_level;
        end
    end

    // sampling state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hist_q    <= CBTS_HIST_RESET;
            sample_q  <= 1'b0;
            bit_q     <= 1'b0;
            bit_end_q <= 1'b0;
        end else begin
            hist_q    <= hist_d;
            sample_q  <= sample_d;
            bit_q     <= bit_d;
            bit_end_q <= bit_end_d;
        end
    end

    // outputs straight from flip-flops
    assign rd_valid       = rd_valid_q;
    assign rd_data        = rd_data_q;
    assign wr_refused     = wr_refused_q;
    assign config_valid   = cfg_valid_q;
    assign sample_strobe  = sample_q;
    assign sampled_bit    = bit_q;
    assign bit_end_strobe = bit_end_q;

    property p_write_taken;
        @(posedge clk) disable iff (!nrst)
        is_wr && in_init |=> seg_q == $past(cmd_wdata) && !wr_refused;
    endproperty
    a_write_taken: assert property (p_write_taken)
        else $error("write in init mode not stored");

    property p_write_blocked;
        @(posedge clk) disable iff (!nrst)
        is_wr && !in_init |=> $stable(seg_q) && wr_refused;
    endproperty
    a_write_blocked: assert property (p_write_blocked)
        else $error("write outside init mode changed register");

    property p_read_back;
        @(posedge clk) disable iff (!nrst)
        is_rd |=> rd_valid && rd_data == $past(seg_q);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read did not return register");

    property p_single_sample;
        @(posedge clk) disable iff (!nrst)
        seg.sample_pt && !tss |=> sample_strobe && sampled_bit == $past(rx_level);
    endproperty
    a_single_sample: assert property (p_single_sample)
        else $error("single sample wrong");

    property p_triple_sample;
        @(posedge clk) disable iff (!nrst)
        seg.sample_pt && tss && hist_q[0] == hist_q[1] |=> sampled_bit == $past(hist_q[0]);
    endproperty
    a_triple_sample: assert property (p_triple_sample)
        else $error("triple sample majority wrong");

    property p_no_run_in_init;
        @(posedge clk) disable iff (!nrst)
        in_init |=> !run_q ##0 !seg.sample_pt;
    endproperty
    a_no_run_in_init: assert property (p_no_run_in_init)
        else $error("bit timing running in init mode");

    property p_read_holds;
        @(posedge clk) disable iff (!nrst)
        !is_rd |=> $stable(rd_data);
    endproperty
    a_read_holds: assert property (p_read_holds)
        else $error("read data changed without a read");

    property p_no_stray_refusal;
        @(posedge clk) disable iff (!nrst)
        !(is_wr && !in_init) |=> !wr_refused;
    endproperty
    a_no_stray_refusal: assert property (p_no_stray_refusal)
        else $error("refusal without a write outside init");

    property p_bit_holds;
        @(posedge clk) disable iff (!nrst)
        !seg.sample_pt |=> $stable(sampled_bit) && !sample_strobe;
    endproperty
    a_bit_holds: assert property (p_bit_holds)
        else $error("sampled bit changed away from a sample point");

    property p_p1_zero_stops;
        @(posedge clk) disable iff (!nrst)
        seg_q[CBTS_P1_MSB:CBTS_P1_LSB] == CBTS_P1_INVALID |=> !run_q && !config_valid;
    endproperty
    a_p1_zero_stops: assert property (p_p1_zero_stops)
        else $error("phase one code zero did not stop bit timing");

    property p_p2_zero_stops;
        @(posedge clk) disable iff (!nrst)
        seg_q[CBTS_P2_MSB:CBTS_P2_LSB] == CBTS_P2_INVALID |=> !run_q && !config_valid;
    endproperty
    a_p2_zero_stops: assert property (p_p2_zero_stops)
        else $error("phase two code zero did not stop bit timing");
endmodule
`default_nettype wire

// ### cbts_pkg.sv
// constants for the bit timing segments register and bit sequencer
`default_nettype none
package cbts_pkg;
    // command codes on the command port
    localparam logic [7:0] CBTS_OP_WRITE     = 8'h1A;
    localparam logic [7:0] CBTS_OP_READ      = 8'hD8;
    // register reset value and field layout
    localparam logic [7:0] CBTS_SEG_RESET    = 8'h00;
    localparam int         CBTS_TSS_BIT      = 7;
    localparam int         CBTS_P2_MSB       = 6;
    localparam int         CBTS_P2_LSB       = 4;
    localparam int         CBTS_P1_MSB       = 3;
    localparam int         CBTS_P1_LSB       = 0;
    // main control operating mode: init when the top bit is set
    localparam int         CBTS_MODE_W       = 3;
    localparam int         CBTS_MODE_INIT    = 2;
    // invalid (reserved) length codes
    localparam logic [3:0] CBTS_P1_INVALID   = 4'h0;
    localparam logic [2:0] CBTS_P2_INVALID   = 3'h0;
    // counter widths and fixed counts
    localparam int         CBTS_CNT_W        = 4;
    localparam logic [3:0] CBTS_CNT_ZERO     = 4'h0;
    localparam logic [3:0] CBTS_CNT_ONE      = 4'h1;
    localparam int         CBTS_BITLEN_W     = 5;
    localparam logic [4:0] CBTS_SYNC_TQ      = 5'h01;
    localparam logic [4:0] CBTS_CODE_OFFSET  = 5'h01;
    localparam logic [1:0] CBTS_HIST_RESET   = 2'h0;

    // segment of the current bit
    typedef enum logic [1:0] {
        CBTS_SEG_SYNC,
        CBTS_SEG_ONE,
        CBTS_SEG_TWO
    } cbts_seg_e;
endpackage
`default_nettype wire

// ### cbts_seg_if.sv
// carrier between the register block and the bit sequencer
`timescale 1ns/10ps
`default_nettype none
interface cbts_seg_if;
    logic [3:0] p1_code;
    logic [2:0] p2_code;
    logic       run;
    logic       tq_tick;
    logic       sample_pt;
    logic       bit_end;

    modport ctrl (output p1_code, output p2_code, output run, output tq_tick,
                  input sample_pt, input bit_end);
    modport seq  (input p1_code, input p2_code, input run, input tq_tick,
                  output sample_pt, output bit_end);
endinterface
`default_nettype wire

// ### cbts_bit_seq.sv
// bit period sequencer: sync quantum, phase one, phase two
`timescale 1ns/10ps
`default_nettype none
module cbts_bit_seq
    import cbts_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    cbts_seg_if.seq   seg
);
    cbts_seg_e             state_q;
    cbts_seg_e             state_d;
    logic [CBTS_CNT_W-1:0] cnt_q;
    logic [CBTS_CNT_W-1:0] cnt_d;

    // strobes at the end of phase one and at the end of the bit
    assign seg.sample_pt = seg.run && seg.tq_tick && state_q == CBTS_SEG_ONE
                           && cnt_q == seg.p1_code;
    assign seg.bit_end   = seg.run && seg.tq_tick && state_q == CBTS_SEG_TWO
                           && cnt_q == {1'b0, seg.p2_code};

    // next segment and quantum count
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (!seg.run) begin
            state_d = CBTS_SEG_SYNC;
            cnt_d   = CBTS_CNT_ZERO;
        end else if (seg.tq_tick) begin
            unique case (state_q)
                CBTS_SEG_SYNC: begin
                    state_d = CBTS_SEG_ONE;
                    cnt_d   = CBTS_CNT_ZERO;
                end
                CBTS_SEG_ONE: begin
                    if (cnt_q == seg.p1_code) begin
                        state_d = CBTS_SEG_TWO;
                        cnt_d   = CBTS_CNT_ZERO;
                    end else begin
                        cnt_d = cnt_q + CBTS_CNT_ONE;
                    end
                end
                CBTS_SEG_TWO: begin
                    if (cnt_q == {1'b0, seg.p2_code}) begin
                        state_d = CBTS_SEG_SYNC;
                        cnt_d   = CBTS_CNT_ZERO;
                    end else begin
                        cnt_d = cnt_q + CBTS_CNT_ONE;
                    end
                end
                default: begin
                    state_d = CBTS_SEG_SYNC;
                    cnt_d   = CBTS_CNT_ZERO;
                end
            endcase
        end
    end

    // segment state registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= CBTS_SEG_SYNC;
            cnt_q   <= CBTS_CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // checking aid: quanta elapsed since the bit began
    logic [CBTS_BITLEN_W-1:0] tq_seen_q;
    logic [CBTS_BITLEN_W-1:0] tq_seen_d;
    always_comb begin
        tq_seen_d = tq_seen_q;
        if (!seg.run || seg.bit_end) begin
            tq_seen_d = '0;
        end else if (seg.tq_tick) begin
            tq_seen_d = tq_seen_q + CBTS_SYNC_TQ;
        end
    end

    // checking aid register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tq_seen_q <= '0;
        end else begin
            tq_seen_q <= tq_seen_d;
        end
    end

    property p_sample_point;
        @(posedge clk) disable iff (!nrst)
        seg.sample_pt |-> tq_seen_q + CBTS_SYNC_TQ ==
            CBTS_SYNC_TQ + {1'b0, seg.p1_code} + CBTS_CODE_OFFSET;
    endproperty
    a_sample_point: assert property (p_sample_point)
        else $error("sample point not at end of phase one");

    property p_bit_length;
        @(posedge clk) disable iff (!nrst)
        seg.bit_end |-> tq_seen_q + CBTS_SYNC_TQ == CBTS_SYNC_TQ
            + {1'b0, seg.p1_code} + CBTS_CODE_OFFSET
            + {2'b00, seg.p2_code} + CBTS_CODE_OFFSET;
    endproperty
    a_bit_length: assert property (p_bit_length)
        else $error("bit period length wrong");

    sequence s_phase_two_starts;
        seg.sample_pt ##1 (state_q == CBTS_SEG_TWO && cnt_q == CBTS_CNT_ZERO);
    endsequence
    property p_phase_two_follows;
        @(posedge clk) disable iff (!nrst)
        seg.sample_pt |-> s_phase_two_starts;
    endproperty
    a_phase_two_follows: assert property (p_phase_two_follows)
        else $error("phase two did not follow sample point");

    property p_p1_len_in_seg;
        @(posedge clk) disable iff (!nrst)
        state_q == CBTS_SEG_ONE |-> cnt_q <= seg.p1_code;
    endproperty
    a_p1_len_in_seg: assert property (p_p1_len_in_seg)
        else $error("phase one count beyond its length");
endmodule
`default_nettype wire

// ### cbts_host_model.sv
// host model: issues register commands and picks legal timing settings
`timescale 1ns/10ps
`default_nettype none
module cbts_host_model
    import cbts_pkg::*;
#(
    parameter int SJW_TQ   = 1,
    parameter bit AIRBORNE = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              rd_valid,
    input  wire logic [7:0]        rd_data,
    input  wire logic              wr_refused,
    output logic                   cmd_valid,
    output logic [7:0]             cmd_opcode,
    output logic [7:0]             cmd_wdata,
    output logic [CBTS_MODE_W-1:0] op_mode
);
    logic       obs_ref;
    logic       obs_rv;
    logic [7:0] obs_rd;

    // idle bus at time zero
    initial begin
        cmd_valid  = 1'b0;
        cmd_opcode = 8'h00;
        cmd_wdata  = 8'h00;
        op_mode    = 3'h4;
    end

    // one command, answer taken half a cycle after the accepting edge
    task automatic cmd(input logic [7:0] op, input logic [7:0] d);
        @(posedge clk);
        cmd_valid  <= 1'b1;
        cmd_opcode <= op;
        cmd_wdata  <= d;
        @(posedge clk);
        cmd_valid  <= 1'b0;
        cmd_opcode <= ~op;  // released lines show junk
        cmd_wdata  <= ~d;
        @(negedge clk);
        obs_ref = wr_refused;
        obs_rv  = rd_valid;
        obs_rd  = rd_data;
    endtask

    task automatic write_reg(input logic [7:0] d);
        cmd(CBTS_OP_WRITE, d);
    endtask

    task automatic read_reg();
        cmd(CBTS_OP_READ, 8'h00);
    endtask

    // init is entered before any reconfiguration
    task automatic set_mode(input logic [CBTS_MODE_W-1:0] m);
        @(posedge clk);
        op_mode <= m;
    endtask

    // settings a careful host would program
    function automatic bit legal_cfg(input logic [7:0] c);
        int p1;
        int p2;
        p1 = int'(c[CBTS_P1_MSB:CBTS_P1_LSB]) + 1;
        p2 = int'(c[CBTS_P2_MSB:CBTS_P2_LSB]) + 1;
        legal_cfg = (p2 > SJW_TQ)
            && (p1 >= p2)
            && (1 + p1 + p2 >= 8);
        // airborne: single sampling, sample point at three quarters or later
        if (AIRBORNE && c[CBTS_TSS_BIT])
            legal_cfg = 1'b0;
        if (AIRBORNE && 4 * (1 + p1) < 3 * (1 + p1 + p2))
            legal_cfg = 1'b0;
    endfunction
endmodule
`default_nettype wire

// ### can_bit_timing_segment_config_bench.sv
// testbench for the bit timing segments register and bit sequencer
`timescale 1ns/10ps
`default_nettype none
module can_bit_timing_segment_config_bench import cbts_pkg::*;;
    logic                   clk;
    logic                   nrst;
    logic                   cmd_valid;
    logic [7:0]             cmd_opcode;
    logic [7:0]             cmd_wdata;
    logic [CBTS_MODE_W-1:0] op_mode;
    logic                   tq_tick;
    logic                   rx_level;
    logic                   rd_valid;
    logic [7:0]             rd_data;
    logic                   wr_refused;
    logic                   config_valid;
    logic                   sample_strobe;
    logic                   sampled_bit;
    logic                   bit_end_strobe;
    int                     err_total;
    int                     samples_checked;
    int                     cycles;
    int                     tk;
    int                     last_end;
    int                     n_strobe;
    logic [2:0]             hist;
    logic                   tick_on;
    logic                   started;
    logic                   valid;
    logic [7:0]             cfg;
    logic [7:0]             regv;
    logic [7:0]             d;

    cbts_top u_cbts_top (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_wdata(cmd_wdata), .op_mode(op_mode),
        .tq_tick(tq_tick), .rx_level(rx_level), .rd_valid(rd_valid), .rd_data(rd_data),
        .wr_refused(wr_refused), .config_valid(config_valid),
        .sample_strobe(sample_strobe), .sampled_bit(sampled_bit),
        .bit_end_strobe(bit_end_strobe));

    // airborne host: random settings keep single sampling and a late sample point
    cbts_host_model #(.AIRBORNE(1'b1)) u_cbts_host_model (.clk(clk), .rd_valid(rd_valid),
        .rd_data(rd_data),
        .wr_refused(wr_refused), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
        .cmd_wdata(cmd_wdata), .op_mode(op_mode));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_sim();
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            err_total++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    function automatic logic maj(input logic [2:0] h);
        return (h[0] & h[1]) | (h[0] & h[2]) | (h[1] & h[2]);
    endfunction

    // quanta from the bit start to the sample point: sync plus phase one
    function automatic int sample_tq(input logic [7:0] c);
        return 1 + int'(c[CBTS_P1_MSB:CBTS_P1_LSB]) + 1;
    endfunction

    // quanta in a whole bit: up to the sample point plus phase two
    function automatic int bit_tq(input logic [7:0] c);
        return sample_tq(c) + int'(c[CBTS_P2_MSB:CBTS_P2_LSB]) + 1;
    endfunction

    // both length codes nonzero
    function automatic logic cfg_ok(input logic [7:0] c);
        return c[CBTS_P1_MSB:CBTS_P1_LSB] != CBTS_P1_INVALID
            && c[CBTS_P2_MSB:CBTS_P2_LSB] != CBTS_P2_INVALID;
    endfunction

    // random ticks and bus level, tick count and level history, timeout
    always @(posedge clk) begin
        tq_tick  <= tick_on && ($urandom % 3 != 0);
        rx_level <= 1'($urandom);
        cycles   <= cycles + 1;
        if (tq_tick) begin
            tk   <= tk + 1;
            hist <= {hist[1:0], rx_level};
        end
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end

    // strobe positions in ticks and the value taken at the sample point
    always @(negedge clk) begin
        if (tick_on && (sample_strobe || bit_end_strobe))
            n_strobe++;
        if (tick_on && sample_strobe && started) begin
            chk_cnt("sample tick", sample_tq(cfg), tk - last_end);
            chk_bit("sampled bit", cfg[7] ? maj(hist) : hist[0], sampled_bit);
        end
        if (tick_on && bit_end_strobe) begin
            if (started)
                chk_cnt("bit ticks", bit_tq(cfg), tk - last_end);
            last_end = tk;
            started  = 1'b1;
        end
    end

    initial begin
        void'($urandom(32'h66E80AA6));
        {tq_tick, rx_level, tick_on, started, hist, cfg} = '0;
        {err_total, samples_checked, cycles, tk, last_end, n_strobe} = '0;
        nrst = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        u_cbts_host_model.read_reg();
        chk_byte("reset value", CBTS_SEG_RESET, u_cbts_host_model.obs_rd);
        chk_bit("config valid", 1'b0, config_valid);
        regv = CBTS_SEG_RESET;
        // every mode: writes land only in init
        for (int m = 0; m < 8; m++) begin
            d = 8'($urandom);
            u_cbts_host_model.set_mode(3'(m));
            u_cbts_host_model.write_reg(d);
            chk_bit("write refused", m < 4, u_cbts_host_model.obs_ref);
            if (m >= 4)
                regv = d;
            u_cbts_host_model.read_reg();
            chk_bit("read answer", 1'b1, u_cbts_host_model.obs_rv);
            chk_byte("read back", regv, u_cbts_host_model.obs_rd);
            chk_bit("config valid", cfg_ok(regv), config_valid);
        end
        // stray command code is ignored
        u_cbts_host_model.set_mode(3'h4);
        u_cbts_host_model.cmd(8'h1B, ~regv);
        chk_bit("stray read answer", 1'b0, u_cbts_host_model.obs_rv);
        chk_bit("stray refusal", 1'b0, u_cbts_host_model.obs_ref);
        u_cbts_host_model.read_reg();
        chk_byte("after stray code", regv, u_cbts_host_model.obs_rd);
        // bit timing: corner settings, invalid codes, then random legal ones
        for (int i = 0; i < 9; i++) begin
            case (i)
                0: cfg = 8'h14;
                1: cfg = 8'hFF;
                2: cfg = 8'h80;
                3: cfg = 8'h07;
                default: do cfg = 8'($urandom); while (!u_cbts_host_model.legal_cfg(cfg));
            endcase
            u_cbts_host_model.set_mode(3'h4);
            u_cbts_host_model.write_reg(cfg);
            u_cbts_host_model.set_mode(3'h0);
            n_strobe = 0;
            started  = 1'b0;
            tick_on <= 1'b1;
            repeat (400) @(posedge clk);
            valid = cfg_ok(cfg);
            chk_bit("strobes seen", valid, n_strobe > 4);
            u_cbts_host_model.set_mode(3'h4);
            repeat (3) @(posedge clk);
            n_strobe = 0;
            repeat (60) @(posedge clk);
            chk_cnt("strobes in init", 0, n_strobe);
            tick_on <= 1'b0;
        end
        end_sim();
    end
endmodule
`default_nettype wire
